/* pmbst_pkg.sv */
// shared constants and types for the pmbus output/input status bytes
// How it works
// - output overvoltage fault sets sticky output-status bit 7
// - output overvoltage warning sets sticky output-status bit 6
// - output undervoltage warning sets sticky output-status bit 5
// - output undervoltage fault sets sticky output-status bit 4
// - commanded voltage outside min/max bounds sets sticky bit 3
// - turn-on time limit exceeded sets sticky output-status bit 2
// - one mask bit gates fixed, tracking and prebiased overvoltage alerts
// - output overcurrent fault sets sticky current-status bit 7
// - output overcurrent warning sets sticky current-status bit 5
// - output undercurrent fault sets sticky current-status bit 4
// - unsupported bit positions read zero and ignore writes
// - clear-faults or writing one clears a sticky bit; zero keeps it
// - host uses write byte to clear and read byte to read
// - input overvoltage fault sets sticky input-status bit 7
// - input undervoltage warning sets sticky input-status bit 5
// - input-status bit 3 is live: 1 when input off, 0 when on
// - live low-input bit also 1 under bias uvlo, never alerts
// - after reset low-input reads asserted without raising alert
// - input undervoltage warning is latched and may alert when unmasked
// - input undervoltage warning suppressed until input first turns on
// - every alert-capable bit has a mask bit; masked bits never alert
// - summary bits are the OR of their detailed status bytes
// - status word bits 15,14,13 flag output voltage, current, input
package pmbst_pkg;
    localparam logic [7:0] PMBST_CMD_VOUT = 8'h7A;
    localparam logic [7:0] PMBST_CMD_IOUT = 8'h7B;
    localparam logic [7:0] PMBST_CMD_INPUT = 8'h7C;
    localparam logic [7:0] PMBST_VOUT_SUPP = 8'hFC;
    localparam logic [7:0] PMBST_IOUT_SUPP = 8'hB0;
    localparam logic [7:0] PMBST_INPUT_STICKY = 8'hA0;
    localparam logic [7:0] PMBST_FLAGS_RESET = 8'h00;
    localparam int PMBST_OUT_OV_FAULT_POS = 7;
    localparam int PMBST_INPUT_UVW_POS = 5;
    localparam int PMBST_INPUT_LIVE_POS = 3;
    localparam int PMBST_WORD_VOUT_POS = 15;
    localparam int PMBST_WORD_IOUT_POS = 14;
    localparam int PMBST_WORD_INPUT_POS = 13;

    typedef struct packed {
        logic out_overvoltage_fault;
        logic out_overvoltage_warn;
        logic out_undervoltage_warn;
        logic out_undervoltage_fault;
        logic out_minmax_violation;
        logic turn_on_timeout;
        logic overcurrent_fault;
        logic overcurrent_warn;
        logic undercurrent_fault;
        logic input_overvoltage_fault;
        logic input_undervoltage_warn;
    } pmbst_events_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } pmbst_access_t;

    typedef struct packed {
        logic vout_summary;
        logic iout_summary;
        logic input_summary;
    } pmbst_summary_t;
endpackage

/* pmbst_flag_byte.sv */
// one status byte of sticky flags with write-one-to-clear
`timescale 1ns/1ps
module pmbst_flag_byte #(
    parameter logic [7:0] SUPPORTED = 8'hFF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] set_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic clear_all_in,
    output logic [7:0] flags_out
);
    import pmbst_pkg::*;

    logic [7:0] flags_next;

    // set wins over a clear arriving in the same cycle
    always_comb begin
        flags_next = flags_out;
        if (clear_all_in) begin
            flags_next = 8'h00;
        end
        if (wr_in) begin
            flags_next = flags_next & ~wdata_in;
        end
        flags_next = (flags_next | set_in) & SUPPORTED;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_out <= PMBST_FLAGS_RESET;
        end else if (ce) begin
            flags_out <= flags_next;
        end
    end

    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !clear_all_in && !wr_in |=> (flags_out & $past(flags_out))
        == $past(flags_out)) else $error("sticky flag dropped");
    flag_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (flags_out & ~SUPPORTED) == 8'h00)
        else $error("unsupported flag set");
endmodule

/* pmbst_status_regs.sv */
// pmbus output voltage, output current and input status bytes
`timescale 1ns/1ps
module pmbst_status_regs (
    input wire logic CORE_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire pmbst_pkg::pmbst_events_t EVENTS_IN,
    input wire logic POWER_INPUT_RAIL_OFF_IN,
    input wire logic BIAS_5V_RAIL_UVLO_IN,
    input wire pmbst_pkg::pmbst_access_t ACCESS_IN,
    input wire logic CLEAR_FAULTS_IN,
    input wire logic [7:0] VOUT_ALERT_MASK_IN,
    input wire logic [7:0] IOUT_ALERT_MASK_IN,
    input wire logic [7:0] INPUT_ALERT_MASK_IN,
    input wire logic [2:0] EXTENDED_ALERT_MASK_IN,
    input wire logic [2:0] OVP_SOURCE_IN,
    output logic [7:0] RDATA_OUT,
    output logic RVALID_OUT,
    output logic ALERT_REQ_OUT,
    output pmbst_pkg::pmbst_summary_t SUMMARY_OUT,
    output logic [15:13] STATUS_WORD_HI_OUT
);
    import pmbst_pkg::*;

    logic [1:0] in_off_sync_reg;
    logic [1:0] uvlo_sync_reg;
    logic input_off_live_bit;
    logic input_seen_on_reg;
    logic [7:0] vout_set;
    logic [7:0] iout_set;
    logic [7:0] input_set;
    logic [7:0] output_voltage_status;
    logic [7:0] output_current_status;
    logic [7:0] input_sticky;
    logic [7:0] input_supply_status;
    logic wr_vout;
    logic wr_iout;
    logic wr_input;
    logic ovp_alert;
    logic [7:0] vout_alertable;
    logic [7:0] iout_alertable;
    logic [7:0] input_alertable;

    // rail levels come from analog comparators, so synchronise them
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            in_off_sync_reg <= 2'b11;
        end else if (CE_IN) begin
            in_off_sync_reg <= {in_off_sync_reg[0], POWER_INPUT_RAIL_OFF_IN};
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            uvlo_sync_reg <= 2'b11;
        end else if (CE_IN) begin
            uvlo_sync_reg <= {uvlo_sync_reg[0], BIAS_5V_RAIL_UVLO_IN};
        end
    end

    // live bit: off if input below turn-on or bias rail in lockout
    assign input_off_live_bit = in_off_sync_reg[1] | uvlo_sync_reg[1];

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            input_seen_on_reg <= 1'b0;
        end else if (CE_IN && !in_off_sync_reg[1]) begin
            input_seen_on_reg <= 1'b1;
        end
    end

    assign vout_set = {EVENTS_IN.out_overvoltage_fault,
                       EVENTS_IN.out_overvoltage_warn,
                       EVENTS_IN.out_undervoltage_warn,
                       EVENTS_IN.out_undervoltage_fault,
                       EVENTS_IN.out_minmax_violation,
                       EVENTS_IN.turn_on_timeout,
                       2'b00};
    assign iout_set = {EVENTS_IN.overcurrent_fault, 1'b0,
                       EVENTS_IN.overcurrent_warn,
                       EVENTS_IN.undercurrent_fault, 4'h0};
    // warning ignored until the input has come up once
    assign input_set = {EVENTS_IN.input_overvoltage_fault, 1'b0,
                        EVENTS_IN.input_undervoltage_warn
                        & input_seen_on_reg, 5'h00};

    // write byte clears, read byte returns one data byte
    assign wr_vout = ACCESS_IN.wr_en && ACCESS_IN.cmd == PMBST_CMD_VOUT;
    assign wr_iout = ACCESS_IN.wr_en && ACCESS_IN.cmd == PMBST_CMD_IOUT;
    assign wr_input = ACCESS_IN.wr_en && ACCESS_IN.cmd == PMBST_CMD_INPUT;

    pmbst_flag_byte #(.SUPPORTED(PMBST_VOUT_SUPP)) u_vout (
        .clk(CORE_CLK_IN),
        .rst_n(RSTN_IN),
        .ce(CE_IN),
        .set_in(vout_set),
        .wr_in(wr_vout),
        .wdata_in(ACCESS_IN.wdata),
        .clear_all_in(CLEAR_FAULTS_IN),
        .flags_out(output_voltage_status)
    );

    pmbst_flag_byte #(.SUPPORTED(PMBST_IOUT_SUPP)) u_iout (
        .clk(CORE_CLK_IN),
        .rst_n(RSTN_IN),
        .ce(CE_IN),
        .set_in(iout_set),
        .wr_in(wr_iout),
        .wdata_in(ACCESS_IN.wdata),
        .clear_all_in(CLEAR_FAULTS_IN),
        .flags_out(output_current_status)
    );

    pmbst_flag_byte #(.SUPPORTED(PMBST_INPUT_STICKY)) u_input (
        .clk(CORE_CLK_IN),
        .rst_n(RSTN_IN),
        .ce(CE_IN),
        .set_in(input_set),
        .wr_in(wr_input),
        .wdata_in(ACCESS_IN.wdata),
        .clear_all_in(CLEAR_FAULTS_IN),
        .flags_out(input_sticky)
    );

    always_comb begin
        input_supply_status = input_sticky;
        input_supply_status[PMBST_INPUT_LIVE_POS] = input_off_live_bit;
    end

    // read data registered; unknown commands return zero
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (CE_IN && ACCESS_IN.rd_en) begin
            unique case (ACCESS_IN.cmd)
                PMBST_CMD_VOUT: RDATA_OUT <= output_voltage_status;
                PMBST_CMD_IOUT: RDATA_OUT <= output_current_status;
                PMBST_CMD_INPUT: RDATA_OUT <= input_supply_status;
                default: RDATA_OUT <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RVALID_OUT <= 1'b0;
        end else if (CE_IN) begin
            RVALID_OUT <= ACCESS_IN.rd_en;
        end
    end

    // shared ovf mask bit gates all three ovp kinds; extended mask splits
    assign ovp_alert = |(OVP_SOURCE_IN & ~EXTENDED_ALERT_MASK_IN);
    always_comb begin
        vout_alertable = output_voltage_status & ~VOUT_ALERT_MASK_IN;
        vout_alertable[PMBST_OUT_OV_FAULT_POS] =
            output_voltage_status[PMBST_OUT_OV_FAULT_POS]
            & ~VOUT_ALERT_MASK_IN[PMBST_OUT_OV_FAULT_POS]
            & (ovp_alert | ~|OVP_SOURCE_IN);
    end
    assign iout_alertable = output_current_status & ~IOUT_ALERT_MASK_IN;
    // live bit excluded: it is information only
    assign input_alertable = input_sticky & ~INPUT_ALERT_MASK_IN;

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ALERT_REQ_OUT <= 1'b0;
        end else if (CE_IN) begin
            ALERT_REQ_OUT <= |{vout_alertable, iout_alertable,
                               input_alertable};
        end
    end

    // summaries follow the detailed bytes; input summary stays set while the live low-input bit is 1
    assign SUMMARY_OUT.vout_summary = |output_voltage_status;
    assign SUMMARY_OUT.iout_summary = |output_current_status;
    assign SUMMARY_OUT.input_summary = |input_supply_status;
    assign STATUS_WORD_HI_OUT = {SUMMARY_OUT.vout_summary,
                                 SUMMARY_OUT.iout_summary,
                                 SUMMARY_OUT.input_summary};

    sequence ovf_event_s;
        CE_IN && EVENTS_IN.out_overvoltage_fault;
    endsequence
    sequence ovf_held_s;
        output_voltage_status[7] [*2];
    endsequence

    ovf_sticky_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        ovf_event_s ##1 (!CLEAR_FAULTS_IN && !wr_vout && CE_IN) |->
        ovf_held_s)
        else $error("overvoltage fault flag not held");
    ovw_set_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        CE_IN && EVENTS_IN.out_overvoltage_warn |=> output_voltage_status[6])
        else $error("overvoltage warn not set");
    ocf_set_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        CE_IN && EVENTS_IN.overcurrent_fault |=> output_current_status[7])
        else $error("overcurrent fault not set");
    uvw_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        !input_seen_on_reg && CE_IN && !wr_input && !CLEAR_FAULTS_IN
        && !input_sticky[5] |=> !input_sticky[5])
        else $error("input warn before first turn-on");
    live_bit_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        input_supply_status[3] == (in_off_sync_reg[1] | uvlo_sync_reg[1]))
        else $error("low-input bit not live");
    clear_all_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        CE_IN && CLEAR_FAULTS_IN && vout_set == 8'h00 |=>
        output_voltage_status == 8'h00)
        else $error("clear faults missed");
    word_map_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        STATUS_WORD_HI_OUT[13] == |input_supply_status
        && STATUS_WORD_HI_OUT[15] == |output_voltage_status)
        else $error("status word summary wrong");
    mask_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        CE_IN && (VOUT_ALERT_MASK_IN & IOUT_ALERT_MASK_IN
        & INPUT_ALERT_MASK_IN) == 8'hFF |=> !ALERT_REQ_OUT)
        else $error("masked bit raised alert");
    live_no_alert_a: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RSTN_IN)
        CE_IN && input_sticky == 8'h00 && output_voltage_status == 8'h00
        && output_current_status == 8'h00 |=> !ALERT_REQ_OUT)
        else $error("live bit raised alert");
endmodule

/* pmbst_host_model.sv */
// host model issuing read byte and write byte strobes
`timescale 1ns/1ps
module pmbst_host_model (
    input wire logic clk_in,
    output pmbst_pkg::pmbst_access_t acc_out
);
    import pmbst_pkg::*;
    initial acc_out = '0;
    // one byte per strobe; released fields flip so stale data never matches
    task automatic xfer(input logic wr, input logic [7:0] cmd,
                        input logic [7:0] d);
        @(negedge clk_in);
        acc_out <= '{wr_en: wr, rd_en: !wr, cmd: cmd, wdata: d};
        @(negedge clk_in);
        acc_out <= '{wr_en: 1'b0, rd_en: 1'b0, cmd: ~cmd, wdata: ~d};
    endtask
endmodule

/* pmbst_status_regs_tb.sv */
// self-checking bench for the status bytes
`timescale 1ns/1ps
module pmbst_status_regs_tb;
    import pmbst_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic off = 1'b1;
    logic uvlo = 1'b0;
    logic clr = 1'b0;
    logic seen_on = 1'b0;
    pmbst_events_t ev = '0;
    pmbst_access_t acc;
    logic [7:0] vm = 8'h00, im = 8'h00, inm = 8'h00;
    logic [2:0] xm = 3'h0, src = 3'h0;
    logic [7:0] rdata;
    logic rvalid, alert;
    pmbst_summary_t summ;
    logic [15:13] word;
    logic [7:0] st [3];
    logic [7:0] expq [$];
    int fails = 0, total_checks = 0, cycles = 0;
    integer seed = 4012;

    always #2 clk = ~clk;

    pmbst_host_model host (.clk_in(clk), .acc_out(acc));

    pmbst_status_regs uut (
        .CORE_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .EVENTS_IN(ev),
        .POWER_INPUT_RAIL_OFF_IN(off), .BIAS_5V_RAIL_UVLO_IN(uvlo),
        .ACCESS_IN(acc), .CLEAR_FAULTS_IN(clr),
        .VOUT_ALERT_MASK_IN(vm), .IOUT_ALERT_MASK_IN(im),
        .INPUT_ALERT_MASK_IN(inm), .EXTENDED_ALERT_MASK_IN(xm),
        .OVP_SOURCE_IN(src), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
        .ALERT_REQ_OUT(alert), .SUMMARY_OUT(summ),
        .STATUS_WORD_HI_OUT(word)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %0t: byte %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %0t: flag %b exp %b", $time, got, exp);
        end
    endtask

    // read results are checked when they appear, oldest note first
    always @(negedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            tally_and_finish();
        end
        if (rvalid === 1'b1) cmp_byte(rdata, expq.pop_front());
    end

    task automatic wait_c(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic rd_all;
        for (int k = 0; k < 3; k++) begin
            expq.push_back(k == 2 ? st[2] | {4'h0, off | uvlo, 3'h0} : st[k]);
            host.xfer(1'b0, PMBST_CMD_VOUT + 8'(k), 8'h00);
        end
    endtask

    task automatic wr(input int k, input logic [7:0] d);
        host.xfer(1'b1, PMBST_CMD_VOUT + 8'(k), d);
        st[k] &= ~d;
    endtask

    task automatic fire(input logic [10:0] e);
        @(negedge clk);
        ev <= e;
        @(negedge clk);
        ev <= '0;
        st[0] |= {e[10:5], 2'h0};
        st[1] |= {e[4], 1'h0, e[3:2], 4'h0};
        st[2] |= {e[1], 1'h0, e[0] & seen_on, 5'h0};
    endtask

    task automatic clear_all;
        @(negedge clk);
        clr <= 1'b1;
        @(negedge clk);
        clr <= 1'b0;
        st = '{default: 8'h00};
    endtask

    // alert is registered behind the flags, so allow it to settle
    task automatic chk_alert(input logic exp);
        wait_c(3);
        cmp_flag(alert, exp);
    endtask

    task automatic chk_sum;
        logic [2:0] s;
        s = {|st[0], |st[1], |st[2] | off | uvlo};
        cmp_byte({2'h0, summ, word}, {2'h0, s, s});
    endtask

    initial begin
        st = '{default: 8'h00};
        repeat (2) @(posedge clk);
        @(negedge clk);
        rstn <= 1'b1;
        cmp_flag(alert, 1'b0);
        rd_all();
        fire(11'h001);
        rd_all();
        chk_alert(1'b0);
        off <= 1'b0;
        wait_c(4);
        seen_on = 1'b1;
        rd_all();
        uvlo <= 1'b1;
        wait_c(4);
        rd_all();
        chk_alert(1'b0);
        uvlo <= 1'b0;
        wait_c(4);
        for (int i = 0; i < 11; i++) begin
            fire(11'h001 << i);
            rd_all();
            chk_alert(1'b1);
            chk_sum();
            for (int k = 0; k < 3; k++) wr(k, 8'h00);
            rd_all();
            for (int k = 0; k < 3; k++) wr(k, 8'hFF);
            rd_all();
            chk_alert(1'b0);
            chk_sum();
        end
        vm <= 8'hFF;
        im <= 8'hFF;
        inm <= 8'hFF;
        fire(11'h7FF);
        chk_alert(1'b0);
        rd_all();
        vm <= 8'h00;
        im <= 8'h00;
        inm <= 8'h00;
        chk_alert(1'b1);
        clear_all();
        rd_all();
        chk_alert(1'b0);
        chk_sum();
        xm <= 3'h1;
        src <= 3'h1;
        fire(11'h400);
        chk_alert(1'b0);
        clear_all();
        src <= 3'h2;
        fire(11'h400);
        chk_alert(1'b1);
        clear_all();
        xm <= 3'h0;
        vm <= 8'h80;
        fire(11'h400);
        chk_alert(1'b0);
        clear_all();
        vm <= 8'h00;
        src <= 3'h0;
        for (int n = 0; n < 16; n++) begin
            fire(11'($random(seed)));
            wr(n % 3, 8'($random(seed)));
            rd_all();
            clear_all();
        end
        // events while the enable is low must leave every flag alone
        @(negedge clk);
        ce <= 1'b0;
        ev <= 11'h7FF;
        @(negedge clk);
        ev <= '0;
        ce <= 1'b1;
        rd_all();
        chk_alert(1'b0);
        expq.push_back(8'h00);
        host.xfer(1'b0, 8'h7D, 8'h00);
        wait_c(3);
        cmp_byte(8'(expq.size()), 8'h00);
        tally_and_finish();
    end
endmodule
